// ===== design/tx_level_compare.sv
// Purpose: Decides whether the transmit FIFO is at or below its threshold.
// Assumes: Level is the current transmit FIFO occupancy.
// Notes: Purely combinational; the caller registers the result.
`timescale 1ns/10ps
`include "uart_fifo_ctrl_int_ident_consts.svh"
module tx_level_compare #(
  parameter int DEPTH = 16,
  parameter int LW = 5
) (
  input wire logic [1:0] tx_empty_threshold_in,
  input wire logic [LW-1:0] level_in,
  output logic at_threshold_out
);
  localparam logic [LW-1:0] TWO = LW'(2);
  localparam logic [LW-1:0] QUARTER = LW'(DEPTH / 4);
  localparam logic [LW-1:0] HALF = LW'(DEPTH / 2);

  always_comb begin
    unique case (tx_empty_threshold_in)
      `TET_EMPTY: at_threshold_out = (level_in == '0);
      `TET_TWO: at_threshold_out = (level_in <= TWO);
      `TET_QUARTER: at_threshold_out = (level_in <= QUARTER);
      `TET_HALF: at_threshold_out = (level_in <= HALF);
    endcase
  end
endmodule : tx_level_compare

// ===== design/uart_fifo_ctrl_int_ident.sv
// Purpose: Shared interrupt-ident / FIFO-control register of a serial port.
// Assumes: Register strobes are one cycle; read data valid next cycle only.
// Notes: FIFO levels and interrupt sources come from the serial core.
// Operation
// - Threshold field picks empty, two left, quarter or half for HOLDING_REG_EMPTY_IRQ.
// - In DMA mode 1 the threshold also paces the transmit request.
// - Low read nibble gives the top pending interrupt code.
// - Bit 3 reads as ident bit 3 and writes the DMA mode.
// - DMA mode bit 0 selects mode 0, 1 selects mode 1.
// - Writing one to bit 2 pulses the transmit FIFO reset; the threshold still takes bits 5:4.
// - The transmit FIFO reset clears itself after one cycle.
// - FIFO enable toggles both FIFOs; any change resets both.
`timescale 1ns/10ps
`include "uart_fifo_ctrl_int_ident_consts.svh"
module uart_fifo_ctrl_int_ident #(
  parameter int TX_DEPTH = 16,
  parameter int RX_DEPTH = 16,
  parameter int LW = 5
) (
  input wire logic clock_in,
  input wire logic rstn_in,
  input wire logic [3:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  input wire logic [LW-1:0] tx_level_in,
  input wire logic [LW-1:0] rx_level_in,
  input wire logic line_status_in,
  input wire logic busy_detect_in,
  input wire logic char_timeout_in,
  input wire logic holding_reg_empty_irq_mode_in,
  output logic tx_fifo_reset_out,
  output logic rx_fifo_reset_out,
  output logic fifo_enable_out,
  output logic dma_tx_req_n_out,
  output logic dma_rx_req_n_out,
  output logic irq_out
);
  logic [1:0] tx_empty_threshold_q, tx_empty_threshold_d;
  logic [1:0] rx_trigger_q, rx_trigger_d;
  uart_fifo_ctrl_int_ident_pkg::dma_mode_e dma_signal_mode_q;
  uart_fifo_ctrl_int_ident_pkg::dma_mode_e dma_signal_mode_d;
  logic fifo_enable_q, fifo_enable_d;
  logic tx_rst_q, tx_rst_d, rx_rst_q, rx_rst_d;
  logic [7:0] rdata_q, rdata_d;
  logic [`EV_COUNT-1:0] irq_stat_q, irq_stat_d, irq_en_q, irq_en_d;
  logic irq_q, irq_d;
  logic dma_tx_n_q, dma_tx_n_d, dma_rx_n_q, dma_rx_n_d;
  logic holding_reg_empty_irq_prev_q, holding_reg_empty_irq_prev_d;
  logic at_threshold;
  logic tx_empty, rx_ready, rx_at_trigger, holding_reg_empty_irq_pending;
  uart_fifo_ctrl_int_ident_pkg::ident_t interrupt_ident_code;
  logic [`EV_COUNT-1:0] events;
  logic wr_fcr;

  tx_level_compare #(
    .DEPTH(TX_DEPTH),
    .LW(LW)
  ) u_tx_cmp (
    .tx_empty_threshold_in(tx_empty_threshold_q),
    .level_in(tx_level_in),
    .at_threshold_out(at_threshold)
  );

  function automatic logic rx_trigger_hit(input logic [1:0] sel,
                                          input logic [LW-1:0] lvl);
    logic hit;
    hit = 1'b0;
    unique case (sel)
      2'h0: hit = (lvl >= LW'(1));
      2'h1: hit = (lvl >= LW'(RX_DEPTH / 4));
      2'h2: hit = (lvl >= LW'(RX_DEPTH / 2));
      2'h3: hit = (lvl >= LW'(RX_DEPTH - 2));
    endcase
    return hit;
  endfunction : rx_trigger_hit

  assign tx_empty = (tx_level_in == '0);
  assign rx_ready = (rx_level_in != '0);
  assign rx_at_trigger = fifo_enable_q ?
      rx_trigger_hit(rx_trigger_q, rx_level_in) : rx_ready;
  // With the programmable mode off the interrupt fires only when empty.
  assign holding_reg_empty_irq_pending = (holding_reg_empty_irq_mode_in && fifo_enable_q) ?
      at_threshold : tx_empty;
  assign wr_fcr = wr_in && (addr_in == `ADDR_IDENT_FCR);

  // Ident is evaluated from live sources, so a read never sees stale codes.
  always_comb begin
    if (line_status_in) begin
      interrupt_ident_code = `ID_RLS;
    end else if (rx_at_trigger) begin
      interrupt_ident_code = `ID_RDA;
    end else if (char_timeout_in) begin
      interrupt_ident_code = `ID_CTO;
    end else if (holding_reg_empty_irq_pending) begin
      interrupt_ident_code = `ID_HOLDING_REG_EMPTY_IRQ;
    end else if (busy_detect_in) begin
      interrupt_ident_code = `ID_BUSY;
    end else begin
      interrupt_ident_code = `ID_NONE;
    end
  end

  always_comb begin
    tx_empty_threshold_d = tx_empty_threshold_q;
    rx_trigger_d = rx_trigger_q;
    dma_signal_mode_d = dma_signal_mode_q;
    fifo_enable_d = fifo_enable_q;
    tx_rst_d = 1'b0;
    rx_rst_d = 1'b0;
    if (wr_fcr) begin
      tx_empty_threshold_d = wdata_in[`TET_HI:`TET_LO];
      rx_trigger_d = wdata_in[`RT_HI:`RT_LO];
      dma_signal_mode_d = wdata_in[`BIT_DMA_MODE] ?
          uart_fifo_ctrl_int_ident_pkg::DMA_MODE1 :
          uart_fifo_ctrl_int_ident_pkg::DMA_MODE0;
      fifo_enable_d = wdata_in[`BIT_FIFO_ENABLE];
      tx_rst_d = wdata_in[`BIT_TX_FIFO_RESET];
      rx_rst_d = wdata_in[`BIT_RX_FIFO_RESET];
      if (wdata_in[`BIT_FIFO_ENABLE] != fifo_enable_q) begin
        tx_rst_d = 1'b1;
        rx_rst_d = 1'b1;
      end
    end
  end

  always_comb begin
    rdata_d = 8'h00;
    if (rd_in) begin
      unique case (addr_in)
        `ADDR_IDENT_FCR: begin
          rdata_d[3:0] = interrupt_ident_code;
          rdata_d[`RT_HI:`RT_LO] = fifo_enable_q ? `FIFO_ON_READ : 2'h0;
        end
        `ADDR_IRQ_STATUS: rdata_d = 8'(irq_stat_q);
        `ADDR_IRQ_ENABLE: rdata_d = 8'(irq_en_q);
        `ADDR_CTRL_STATUS: rdata_d = {4'h0, dma_signal_mode_q[0],
                                      fifo_enable_q, tx_empty_threshold_q};
        default: rdata_d = 8'h00;
      endcase
    end
  end

  // Events: the hardware set wins over a same-cycle software clear.
  always_comb begin
    events = '0;
    events[`EV_TX_RESET] = tx_rst_q;
    events[`EV_RX_RESET] = rx_rst_q;
    events[`EV_FIFO_ENABLE_BIT_CHANGE] = wr_fcr &&
        (wdata_in[`BIT_FIFO_ENABLE] != fifo_enable_q);
    events[`EV_HOLDING_REG_EMPTY_IRQ] = holding_reg_empty_irq_pending && !holding_reg_empty_irq_prev_q;
    holding_reg_empty_irq_prev_d = holding_reg_empty_irq_pending;
    irq_en_d = irq_en_q;
    irq_stat_d = irq_stat_q;
    if (wr_in && addr_in == `ADDR_IRQ_ENABLE) begin
      irq_en_d = wdata_in[`EV_COUNT-1:0];
    end
    if (wr_in && addr_in == `ADDR_IRQ_CLEAR) begin
      irq_stat_d = irq_stat_q & ~wdata_in[`EV_COUNT-1:0];
    end
    irq_stat_d = irq_stat_d | events;
    irq_d = |(irq_stat_d & irq_en_d);
  end

  // Mode 0 follows single-transfer readiness; mode 1 uses the thresholds.
  always_comb begin
    if (dma_signal_mode_q == uart_fifo_ctrl_int_ident_pkg::DMA_MODE1) begin
      dma_tx_n_d = !at_threshold;
      dma_rx_n_d = !rx_at_trigger;
    end else begin
      dma_tx_n_d = !(tx_level_in < LW'(TX_DEPTH));
      dma_rx_n_d = !rx_ready;
    end
    // A FIFO being reset has nothing valid to move.
    if (tx_rst_q) begin
      dma_tx_n_d = 1'b1;
    end
    if (rx_rst_q) begin
      dma_rx_n_d = 1'b1;
    end
  end

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      tx_empty_threshold_q <= `TET_EMPTY;
      rx_trigger_q <= 2'h0;
      dma_signal_mode_q <= uart_fifo_ctrl_int_ident_pkg::DMA_MODE0;
      fifo_enable_q <= `RESET_FIFO_ENABLE;
      tx_rst_q <= 1'b0;
      rx_rst_q <= 1'b0;
      rdata_q <= 8'h00;
      irq_stat_q <= '0;
      irq_en_q <= '0;
      irq_q <= 1'b0;
      holding_reg_empty_irq_prev_q <= 1'b0;
      dma_tx_n_q <= 1'b1;
      dma_rx_n_q <= 1'b1;
    end else begin
      tx_empty_threshold_q <= tx_empty_threshold_d;
      rx_trigger_q <= rx_trigger_d;
      dma_signal_mode_q <= dma_signal_mode_d;
      fifo_enable_q <= fifo_enable_d;
      tx_rst_q <= tx_rst_d;
      rx_rst_q <= rx_rst_d;
      rdata_q <= rdata_d;
      irq_stat_q <= irq_stat_d;
      irq_en_q <= irq_en_d;
      irq_q <= irq_d;
      holding_reg_empty_irq_prev_q <= holding_reg_empty_irq_prev_d;
      dma_tx_n_q <= dma_tx_n_d;
      dma_rx_n_q <= dma_rx_n_d;
    end
  end

  assign rdata_out = rdata_q;
  assign tx_fifo_reset_out = tx_rst_q;
  assign rx_fifo_reset_out = rx_rst_q;
  assign fifo_enable_out = fifo_enable_q;
  assign dma_tx_req_n_out = dma_tx_n_q;
  assign dma_rx_req_n_out = dma_rx_n_q;
  assign irq_out = irq_q;
endmodule : uart_fifo_ctrl_int_ident

// ===== design/uart_fifo_ctrl_int_ident_consts.svh
// Purpose: Register offsets, field positions and codes for the ident block.
// Assumes: Word-indexed register port, 8-bit data.
// Notes: Offsets are local to this block.
`ifndef UART_FIFO_CTRL_INT_IDENT_CONSTS_SVH
`define UART_FIFO_CTRL_INT_IDENT_CONSTS_SVH

`define ADDR_IDENT_FCR 4'h0
`define ADDR_IRQ_STATUS 4'h1
`define ADDR_IRQ_ENABLE 4'h2
`define ADDR_IRQ_CLEAR 4'h3
`define ADDR_CTRL_STATUS 4'h4

`define BIT_FIFO_ENABLE 0
`define BIT_RX_FIFO_RESET 1
`define BIT_TX_FIFO_RESET 2
`define BIT_DMA_MODE 3
`define TET_LO 4
`define TET_HI 5
`define RT_LO 6
`define RT_HI 7

`define ID_NONE 4'h1
`define ID_HOLDING_REG_EMPTY_IRQ 4'h2
`define ID_RDA 4'h4
`define ID_RLS 4'h6
`define ID_BUSY 4'h7
`define ID_CTO 4'hC

`define TET_EMPTY 2'h0
`define TET_TWO 2'h1
`define TET_QUARTER 2'h2
`define TET_HALF 2'h3

`define FIFO_ON_READ 2'h3
`define RESET_FIFO_ENABLE 1'h1

`define EV_TX_RESET 0
`define EV_RX_RESET 1
`define EV_FIFO_ENABLE_BIT_CHANGE 2
`define EV_HOLDING_REG_EMPTY_IRQ 3
`define EV_COUNT 4

`endif

// ===== design/uart_fifo_ctrl_int_ident_pkg.sv
// Purpose: Shared types of the ident block.
// Assumes: Used by uart_fifo_ctrl_int_ident only; tx_level_compare does not import it.
// Notes: Codes for the ident nibble are in the constants header.
package uart_fifo_ctrl_int_ident_pkg;
  typedef enum logic [1:0] {
    DMA_MODE0 = 2'h0,
    DMA_MODE1 = 2'h1
  } dma_mode_e;
  typedef logic [3:0] ident_t;
endpackage : uart_fifo_ctrl_int_ident_pkg

// ===== verif/dma_partner_model.sv
// Purpose: DMA controller answering the request lines.
// Assumes: Requests are active low levels.
// Notes: Slow mode serves only every other cycle.
`timescale 1ns/10ps
module dma_partner_model (
  input wire logic clock_in,
  input wire logic rstn_in,
  input wire logic slow_in,
  input wire logic tx_req_n_in,
  input wire logic rx_req_n_in,
  output int served_out
);
  logic phase_q;
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      phase_q <= 1'b0;
      served_out <= 0;
    end else begin
      phase_q <= !phase_q;
      if ((!tx_req_n_in || !rx_req_n_in) && (!slow_in || phase_q)) begin
        served_out <= served_out + 1;
      end
    end
  end
endmodule : dma_partner_model

// ===== verif/testbench.sv
// Purpose: Self-checking bench for the ident/FIFO-control register.
// Assumes: Transmit depth 16, receive trigger left at one character.
// Notes: Sources are randomised from a fixed seed.
`timescale 1ns/10ps
module testbench;
  logic clock_in, rstn_in, wr_in, rd_in, line_status_in, busy_detect_in;
  logic char_timeout_in, holding_reg_empty_irq_mode_in, slow, tx_rst, rx_rst, fen, txr_n;
  logic rxr_n, irq;
  logic [3:0] addr_in;
  logic [7:0] wdata_in, rdata_out;
  logic [4:0] tx_level_in, rx_level_in;
  logic [31:0] seed;
  int fails, cmp_count, served, tx_empty_threshold, mode, txl, rxl, exp;
  int tx_holding_register[4] = '{0, 2, 4, 8};
  uart_fifo_ctrl_int_ident dut (.clock_in(clock_in), .rstn_in(rstn_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .tx_level_in(tx_level_in),
    .rx_level_in(rx_level_in), .line_status_in(line_status_in),
    .busy_detect_in(busy_detect_in), .char_timeout_in(char_timeout_in),
    .holding_reg_empty_irq_mode_in(holding_reg_empty_irq_mode_in), .tx_fifo_reset_out(tx_rst),
    .rx_fifo_reset_out(rx_rst), .fifo_enable_out(fen),
    .dma_tx_req_n_out(txr_n), .dma_rx_req_n_out(rxr_n), .irq_out(irq));
  dma_partner_model dma (.clock_in(clock_in), .rstn_in(rstn_in),
    .slow_in(slow), .tx_req_n_in(txr_n), .rx_req_n_in(rxr_n),
    .served_out(served));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs
  task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", nm, e, g);
      fails++;
    end
  endtask : chk
  task automatic tick(int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask : tick
  task automatic wr(logic [3:0] a, logic [7:0] d);
    @(posedge clock_in);
    wr_in <= 1'b1;
    addr_in <= a;
    wdata_in <= d;
    @(posedge clock_in);
    wr_in <= 1'b0;
  endtask : wr
  task automatic rd(logic [3:0] a, logic [7:0] m, logic [7:0] e);
    @(posedge clock_in);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge clock_in);
    rd_in <= 1'b0;
    #1;
    chk("rdata", e, rdata_out & m);
  endtask : rd
  task automatic summarize();
    $display("Comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : summarize
  initial begin
    clock_in = 1'b0;
    forever #4 clock_in = ~clock_in;
  end
  initial begin
    repeat (100000) @(posedge clock_in);
    fails++;
    summarize();
  end
  initial begin
    {rstn_in, wr_in, rd_in, line_status_in, busy_detect_in} = '0;
    {char_timeout_in, holding_reg_empty_irq_mode_in, slow, addr_in, wdata_in} = '0;
    {tx_level_in, rx_level_in} = '0;
    fails = 0;
    cmp_count = 0;
    seed = 32'hCF6DF54E;
    repeat (16) @(posedge clock_in);
    rstn_in <= 1'b1;
    #1;
    chk("reset", 8'h0E, {irq, tx_rst, rx_rst, 1'b0, fen, txr_n, rxr_n, 1'b0});
    rd(4'h4, 8'h0F, 8'h04);
    for (int i = 0; i < 24; i++) begin
      seed = xs(seed);
      txl = seed[4:0] % 17;
      rxl = seed[6:5];
      tx_empty_threshold = seed[8:7];
      mode = seed[9];
      @(posedge clock_in);
      tx_level_in <= 5'(txl);
      rx_level_in <= 5'(rxl);
      line_status_in <= seed[10] & seed[11];
      char_timeout_in <= seed[12] & seed[13];
      busy_detect_in <= seed[14];
      holding_reg_empty_irq_mode_in <= seed[15];
      slow <= seed[16];
      wr(4'h0, 8'(tx_empty_threshold * 16 + mode * 8 + 1));
      tick(2);
      exp = (seed[15] ? txl <= tx_holding_register[tx_empty_threshold] : txl == 0) ? 2 : seed[14] ? 7 : 1;
      exp = seed[10] & seed[11] ? 6 : rxl > 0 ? 4 : seed[13:12] == 3 ? 12 : exp;
      rd(4'h0, 8'hFF, 8'(exp + 8'hC0));
      chk("tx req", 8'(mode ? txl > tx_holding_register[tx_empty_threshold] : txl > 15), 8'(txr_n));
      chk("rx req", 8'(rxl == 0), 8'(rxr_n));
      rd(4'h4, 8'h0F, 8'(mode * 8 + 4 + tx_empty_threshold));
    end
    chk("dma served", 8'h01, 8'(served > 0));
    wr(4'h3, 8'h0F);
    wr(4'h2, 8'h01);
    wr(4'h0, 8'h05);
    #1;
    chk("tx pulse", 8'h02, {6'h0, tx_rst, rx_rst});
    tick(1);
    chk("tx pulse end", 8'h00, {6'h0, tx_rst, rx_rst});
    tick(1);
    chk("irq", 8'h01, 8'(irq));
    rd(4'h1, 8'h01, 8'h01);
    rd(4'h3, 8'hFF, 8'h00);
    wr(4'h3, 8'h01);
    tick(2);
    chk("irq cleared", 8'h00, 8'(irq));
    wr(4'h2, 8'h00);
    wr(4'h0, 8'h05);
    tick(3);
    chk("irq masked", 8'h00, 8'(irq));
    rd(4'h1, 8'h01, 8'h01);
    wr(4'h0, 8'h00);
    #1;
    chk("both resets", 8'h03, {6'h0, tx_rst, rx_rst});
    rd(4'h0, 8'hF0, 8'h00);
    rd(4'h1, 8'h04, 8'h04);
    wr(4'h0, 8'h01);
    #1;
    chk("both resets", 8'h03, {6'h0, tx_rst, rx_rst});
    rd(4'h9, 8'hFF, 8'h00);
    wr(4'h9, 8'hFF);
    rd(4'h4, 8'h0F, 8'h04);
    summarize();
  end
endmodule : testbench

// ===== verif/uart_ident_monitor.sv
// Purpose: Port assertions for the ident and FIFO-control register.
// Assumes: Index 0 is the shared ident/control register.
// Notes: Sees the top-level ports only.
`timescale 1ns/10ps
module uart_ident_monitor (
  input wire logic clock_in,
  input wire logic rstn_in,
  input wire logic [3:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [7:0] rdata_out,
  input wire logic line_status_in,
  input wire logic tx_fifo_reset_out,
  input wire logic rx_fifo_reset_out,
  input wire logic fifo_enable_out,
  input wire logic dma_tx_req_n_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rstn_in);
  logic w0;
  logic r0;
  assign w0 = wr_in && addr_in == 4'h0;
  assign r0 = rd_in && addr_in == 4'h0;
  tx_reset_pulse_a: assert property (
    w0 && wdata_in[2] |=> tx_fifo_reset_out) else $error("No tx reset.");
  tx_self_clear_a: assert property (
    tx_fifo_reset_out && !wr_in |=> !tx_fifo_reset_out)
    else $error("Tx reset stuck.");
  no_false_reset_a: assert property (
    w0 && !wdata_in[2] && wdata_in[0] == fifo_enable_out
    |=> !tx_fifo_reset_out) else $error("Spurious tx reset.");
  rdata_idle_a: assert property (
    !rd_in |=> rdata_out == 8'h00) else $error("Read data not idle.");
  enable_reset_a: assert property (
    w0 && wdata_in[0] != fifo_enable_out
    |=> tx_fifo_reset_out && rx_fifo_reset_out)
    else $error("Enable change without resets.");
  enable_follow_a: assert property (
    w0 |=> fifo_enable_out == $past(wdata_in[0]))
    else $error("Enable not written.");
  ident_high_a: assert property (
    r0 |=> rdata_out[7:4] == {{2{fifo_enable_out}}, 2'b00})
    else $error("Ident high bits wrong.");
  // Source held two edges so read latency of the source cannot matter.
  line_prio_a: assert property (
    r0 && line_status_in && $past(line_status_in)
    |=> rdata_out[3:0] == 4'h6) else $error("Line status not top.");
  req_block_a: assert property (
    tx_fifo_reset_out |=> dma_tx_req_n_out) else $error("Request in reset.");
  cover property (w0 && wdata_in[2]);
  cover property (r0 && line_status_in);
  cover property (w0 && wdata_in[3]);
endmodule : uart_ident_monitor

bind uart_fifo_ctrl_int_ident uart_ident_monitor mon (.*);
